/* core/eep_cfg.svh */
`ifndef EEP_CFG_SVH
`define EEP_CFG_SVH
`define EEP_CLK_MHZ       50
`define EEP_GLITCH_NS     50
`define EEP_GLITCH_CYC    ((`EEP_GLITCH_NS * `EEP_CLK_MHZ + 999) / 1000)
`define EEP_DEV_CODE      4'ha
`define EEP_SEL_LOC       9'h109
`define EEP_LOAD_MS       10
`define EEP_LOAD_CYC      (`EEP_LOAD_MS * 1000 * `EEP_CLK_MHZ)
`define EEP_TWC_MS        5
`define EEP_TWC_CYC       (`EEP_TWC_MS * 1000 * `EEP_CLK_MHZ)
`define EEP_LAST_ADDR     9'h1ff
`define EEP_PAGE_BYTES    8
`define EEP_FIFO_DEPTH    16
`endif

/* core/eep_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module eep_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             clr,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  assign in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_reg != rd_reg;
  assign out_data  = mem[rd_reg[AW-1:0]];
  always_ff @(posedge sys_clk) begin
    if (in_valid && in_ready) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else if (clr) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (in_valid && in_ready) wr_reg <= wr_reg + 1'b1;
      if (out_valid && out_ready) rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule : eep_fifo
`default_nettype wire

/* core/eep_pkg.sv */
package eep_pkg;
  typedef enum logic [2:0] {
    EEP_IDLE, EEP_DEVADR, EEP_ADRHI, EEP_ADRLO, EEP_WDATA, EEP_RDATA,
    EEP_RACK
  } eep_state_t;
endpackage : eep_pkg

/* core/eep_slave.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eep_cfg.svh"
module eep_slave
  import eep_pkg::*;
#(
  parameter int LOAD_CYC = `EEP_LOAD_CYC,
  parameter int TWC_CYC  = `EEP_TWC_CYC
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  output logic      busy,
  output logic      loading
);
  localparam int GC = `EEP_GLITCH_CYC;
  logic [7:0] mem [512];
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic [2:0] scl_cnt;
  logic [2:0] sda_cnt;
  logic       scl_reg;
  logic       sda_reg;
  logic       scl_d;
  logic       sda_d;
  // Three stages; first flop only feeds the second
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end
  // A level must persist GC cycles before it is accepted
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scl_cnt <= 3'h0;
      sda_cnt <= 3'h0;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      if (scl_sync[2] != scl_sync[1] || scl_sync[2] == scl_reg)
        scl_cnt <= 3'h0;
      else if (scl_cnt == 3'(GC - 1))
        scl_reg <= scl_sync[2];
      else
        scl_cnt <= scl_cnt + 3'h1;
      if (sda_sync[2] != sda_sync[1] || sda_sync[2] == sda_reg)
        sda_cnt <= 3'h0;
      else if (sda_cnt == 3'(GC - 1))
        sda_reg <= sda_sync[2];
      else
        sda_cnt <= sda_cnt + 3'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_reg;
      sda_d <= sda_reg;
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl_reg && !scl_d;
  assign scl_fall = !scl_reg && scl_d;
  assign start_ev = scl_reg && scl_d && sda_d && !sda_reg;
  assign stop_ev  = scl_reg && scl_d && !sda_d && sda_reg;

  // Select code load LOAD_CYC cycles after reset release
  logic [31:0] load_cnt;
  logic [2:0]  slave_select_compare_reg;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      load_cnt                 <= 32'h0;
      loading                  <= 1'b1;
      slave_select_compare_reg <= 3'h0;
    end else if (loading) begin
      if (load_cnt == 32'(LOAD_CYC - 1)) begin
        loading                  <= 1'b0;
        slave_select_compare_reg <= mem[`EEP_SEL_LOC][2:0];
      end else begin
        load_cnt <= load_cnt + 32'h1;
      end
    end
  end

  eep_state_t  state_reg;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift_reg;
  logic [7:0]  adr_hi_reg;
  logic [8:0]  ctr_reg;
  logic [3:0]  data_cnt;
  logic        ack_phase;
  logic        ack_val;
  logic        master_ack;
  logic        twc_start;
  logic [31:0] twc_cnt;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [16:0] fifo_out;
  logic        fifo_wr;
  logic        drain;
  logic [7:0]  rd_byte;
  logic [7:0]  byte_in;

  assign byte_in = {shift_reg[6:0], sda_reg};

  // Write cycle timer; pending bytes drain into the array meanwhile
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy    <= 1'b0;
      twc_cnt <= 32'h0;
    end else if (twc_start) begin
      busy    <= 1'b1;
      twc_cnt <= 32'h0;
    end else if (busy) begin
      if (twc_cnt >= 32'(TWC_CYC - 1) && !fifo_out_valid)
        busy <= 1'b0;
      else
        twc_cnt <= twc_cnt + 32'h1;
    end
  end
  assign drain = busy;
  // Erased image with the factory select code 0; the array has no reset
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'hff;
    mem[`EEP_SEL_LOC] = 8'h00;
  end
  // Bytes land in order, so a repeated location keeps the last one
  always @(posedge sys_clk) begin
    if (drain && fifo_out_valid)
      mem[fifo_out[16:8]] <= fifo_out[7:0];
  end

  eep_fifo #(.WIDTH(17), .DEPTH(`EEP_FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .clr       (1'b0),
    .in_valid  (fifo_wr),
    .in_ready  (fifo_in_ready),
    .in_data   ({ctr_reg, byte_in}),
    .out_valid (fifo_out_valid),
    .out_ready (drain),
    .out_data  (fifo_out)
  );

  assign rd_byte = mem[ctr_reg];
  // A ninth byte is refused (nack) so the FIFO takes at most one page per start condition
  assign fifo_wr = scl_rise && !ack_phase && state_reg == EEP_WDATA &&
                   bit_cnt == 4'h7 && fifo_in_ready &&
                   data_cnt < 4'(`EEP_PAGE_BYTES);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= EEP_IDLE;
      bit_cnt    <= 4'h0;
      shift_reg  <= 8'h00;
      adr_hi_reg <= 8'h00;
      ctr_reg    <= 9'h000;
      data_cnt   <= 4'h0;
      ack_phase  <= 1'b0;
      ack_val    <= 1'b1;
      master_ack <= 1'b1;
      twc_start  <= 1'b0;
    end else begin
      twc_start <= 1'b0;
      if (stop_ev) begin
        if (state_reg == EEP_WDATA && data_cnt != 4'h0 && !busy)
          twc_start <= 1'b1;
        state_reg <= EEP_IDLE;
        ack_phase <= 1'b0;
      end else if (start_ev) begin
        state_reg <= loading ? EEP_IDLE : EEP_DEVADR;
        bit_cnt   <= 4'h0;
        ack_phase <= 1'b0;
        data_cnt  <= 4'h0;
      end else if (scl_rise && !ack_phase) begin
        case (state_reg)
          EEP_RACK: begin
            master_ack <= sda_reg;
            state_reg  <= sda_reg ? EEP_IDLE : EEP_RDATA;
            bit_cnt    <= 4'h0;
          end
          EEP_RDATA: begin
            bit_cnt <= bit_cnt + 4'h1;
          end
          EEP_IDLE: begin
          end
          default: begin
            shift_reg <= byte_in;
            bit_cnt   <= bit_cnt + 4'h1;
            if (bit_cnt == 4'h7) begin
              ack_phase <= 1'b1;
              ack_val   <= 1'b1;
              case (state_reg)
                EEP_DEVADR: begin
                  if (byte_in[7:4] == `EEP_DEV_CODE &&
                      byte_in[3:1] == slave_select_compare_reg) begin
                    if (busy)
                      ack_val <= 1'b1;
                    else
                      ack_val <= 1'b0;
                  end
                end
                EEP_ADRHI: ack_val <= 1'b0;
                EEP_ADRLO: ack_val <= 1'b0;
                EEP_WDATA: ack_val <= !fifo_wr;
                default:   ack_val <= 1'b1;
              endcase
            end
          end
        endcase
      end else if (scl_fall && ack_phase && bit_cnt == 4'h8) begin
        // Ack bit driven for the ninth clock
        bit_cnt <= 4'h9;
      end else if (scl_fall && ack_phase && bit_cnt == 4'h9) begin
        ack_phase <= 1'b0;
        bit_cnt   <= 4'h0;
        if (ack_val) begin
          // A refused ninth byte keeps the page so the stop still programs
          state_reg <= (state_reg == EEP_WDATA) ? EEP_WDATA : EEP_IDLE;
        end else begin
          case (state_reg)
            EEP_DEVADR:
              state_reg <= shift_reg[0] ? EEP_RDATA : EEP_ADRHI;
            EEP_ADRHI: begin
              adr_hi_reg <= shift_reg;
              state_reg  <= EEP_ADRLO;
            end
            EEP_ADRLO: begin
              ctr_reg   <= {adr_hi_reg[0], shift_reg};
              state_reg <= EEP_WDATA;
            end
            EEP_WDATA: begin
              data_cnt <= data_cnt + 4'h1;
              ctr_reg  <= {ctr_reg[8:3], ctr_reg[2:0] + 3'h1};
            end
            default: state_reg <= EEP_IDLE;
          endcase
        end
      end else if (state_reg == EEP_RDATA && scl_fall && bit_cnt == 4'h8) begin
        ctr_reg   <= ctr_reg + 9'h001;
        state_reg <= EEP_RACK;
      end
    end
  end

  // Open-drain drive: pull low only; released on start, stop and other SCL falls
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sda_oe <= 1'b0;
    end else if (stop_ev || start_ev) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      if (ack_phase && bit_cnt == 4'h8)
        sda_oe <= !ack_val;
      else if (ack_phase && bit_cnt == 4'h9 && state_reg == EEP_DEVADR &&
               !ack_val && shift_reg[0])
        sda_oe <= !rd_byte[7];
      else if (state_reg == EEP_RDATA && bit_cnt < 4'h8 &&
               !(ack_phase && bit_cnt == 4'h9))
        sda_oe <= !rd_byte[3'(7 - bit_cnt)];
      else
        sda_oe <= 1'b0;
    end
  end
  // A read right after an acked address needs bit 7 on the first fall
  assign sda_out = 1'b0;

  p_busy_after_stop: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(busy) |-> $past(twc_start))
    else $error("busy rose without a stop");
  a_busy_after_stop: assert property (@(posedge sys_clk) disable iff (!nrst)
    twc_start |=> busy)
    else $error("write cycle did not start");
  a_no_drive_loading: assert property (@(posedge sys_clk) disable iff (!nrst)
    loading |-> !sda_oe)
    else $error("sda driven while loading");
  a_page_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == EEP_WDATA && $past(state_reg) == EEP_WDATA &&
     $changed(ctr_reg)) |->
      ctr_reg[8:3] == $past(ctr_reg[8:3]))
    else $error("page write left its page");
  a_page_limit: assert property (@(posedge sys_clk) disable iff (!nrst)
    data_cnt <= 4'h8)
    else $error("more than eight bytes accepted");
  a_no_empty_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    twc_start |-> $past(data_cnt) != 4'h0)
    else $error("write cycle with no data");
  a_busy_nack: assert property (@(posedge sys_clk) disable iff (!nrst)
    (busy && ack_phase && state_reg == EEP_DEVADR) |-> ack_val)
    else $error("acked while busy");
  a_read_inc: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == EEP_RDATA && scl_fall && bit_cnt == 4'h8) |=>
      ctr_reg == $past(ctr_reg) + 9'h001)
    else $error("read counter not advanced");
  c_write: cover property (@(posedge sys_clk) twc_start);
  c_read: cover property (@(posedge sys_clk) state_reg == EEP_RACK);
  c_wrap: cover property (@(posedge sys_clk)
    state_reg == EEP_RDATA && ctr_reg == 9'h000);
endmodule : eep_slave
`default_nettype wire

/* dv/eep_i2c_master.sv */
`timescale 1ns/1ps
`default_nettype none
module eep_i2c_master (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  // Quarter of a 320 ns SCL period; 160 ns leaves no room for the
  // slave's input filter and ack latency inside the low phase
  localparam int Q = 80;

  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic xfer(input logic b, output logic r);
    #Q sda_drv = b;
    #Q scl = 1'b1;
    #140 r = sda;
    #20 scl = 1'b0;
  endtask : xfer

  // Also serves as repeated start; waits out the slave's ack release
  task automatic start();
    #(2*Q) sda_drv = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
  endtask : start

  task automatic stop();
    #Q sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #Q;
  endtask : stop

  task automatic byte_io(input  logic [7:0] tx,
                         input  logic       ak_tx,
                         output logic [7:0] rx,
                         output logic       ak_rx);
    for (int i = 7; i >= 0; i--) xfer(tx[i], rx[i]);
    xfer(ak_tx, ak_rx);
  endtask : byte_io

  // 20 ns SCL pulse in a low phase, below the noise limit
  task automatic glitch();
    #(2*Q) scl = 1'b1;
    #20 scl = 1'b0;
  endtask : glitch
endmodule : eep_i2c_master
`default_nettype wire

/* dv/i2c_eeprom_access_protocol_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_eeprom_access_protocol_tb;
  logic        sys_clk, nrst, scl, m_sda, sda_out, sda_oe, busy, loading;
  wire logic   sda;
  logic [7:0]  mem [512];
  bit          known [512];
  int          ctr, bad_count, tests_run;
  logic [15:0] rnd;
  logic [7:0]  rx;
  logic        ak;

  // Open drain with pull-up: low if either side pulls
  assign sda = m_sda & ~(sda_oe & ~sda_out);

  eep_slave #(.LOAD_CYC(250), .TWC_CYC(300)) u_eep_slave (
    .sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy), .loading(loading));
  eep_i2c_master u_eep_i2c_master (.scl(scl), .sda_drv(m_sda), .sda(sda));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : check

  task automatic finish_test();
    $display("mismatches %0d, checks %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic settle(input bit ld, input logic v, input int lim);
    for (int i = 0; i < lim && (ld ? loading : busy) !== v; i++)
      @(posedge sys_clk);
    check({7'h0, ld ? loading : busy}, {7'h0, v}, "status level");
  endtask : settle

  task automatic dev(input logic [7:0] a, input logic exp_ak);
    u_eep_i2c_master.start();
    u_eep_i2c_master.byte_io(a, 1'b1, rx, ak);
    check({7'h0, ak}, {7'h0, exp_ak}, "address ack");
  endtask : dev

  task automatic adr(input logic [15:0] a);
    u_eep_i2c_master.byte_io(a[15:8], 1'b1, rx, ak);
    check({7'h0, ak}, 8'h0, "high address ack");
    u_eep_i2c_master.glitch();
    u_eep_i2c_master.byte_io(a[7:0], 1'b1, rx, ak);
    check({7'h0, ak}, 8'h0, "low address ack");
  endtask : adr

  task automatic wr(input logic [15:0] a, input int n);
    logic [8:0] p;
    dev(8'ha0, 1'b0);
    adr(a);
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      p = {a[8:3], a[2:0] + 3'(i)};
      u_eep_i2c_master.byte_io(rnd[7:0], 1'b1, rx, ak);
      check({7'h0, ak}, {7'h0, i >= 8}, "data ack");
      if (i < 8) begin
        mem[p] = rnd[7:0];
        known[p] = 1'b1;
        ctr = {p[8:3], p[2:0] + 3'd1};
      end
    end
    check({7'h0, busy}, 8'h0, "busy before stop");
    u_eep_i2c_master.stop();
    settle(0, 1'b1, 20);
    dev(8'ha0, 1'b1);
    u_eep_i2c_master.stop();
    settle(0, 1'b0, 400);
    dev(8'ha0, 1'b0);
    u_eep_i2c_master.stop();
  endtask : wr

  task automatic rd(input int n);
    dev(8'ha1, 1'b0);
    for (int i = 0; i < n; i++) begin
      u_eep_i2c_master.byte_io(8'hff, i == n - 1, rx, ak);
      if (known[ctr]) check(rx, mem[ctr], "read data");
      ctr = (ctr + 1) % 512;
    end
    u_eep_i2c_master.stop();
  endtask : rd

  initial begin
    nrst = 1'b0;
    rnd = 16'h6584;
    bad_count = 0;
    tests_run = 0;
    ctr = 0;
    repeat (2) @(posedge sys_clk);
    check({5'h0, sda_oe, busy, loading}, 8'h01, "reset values");
    nrst <= 1'b1;
    dev(8'ha0, 1'b1);
    u_eep_i2c_master.stop();
    settle(1, 1'b0, 400);
    wr(16'h0000, 1);
    wr(16'h03fe, 8);
    wr(16'h01f9, 7);
    rd(10);
    wr(16'h01f9, 9);
    dev(8'ha0, 1'b0);
    adr(16'h01ff);
    ctr = 'h1ff;
    rd(1);
    rd(1);
    settle(0, 1'b0, 1);
    dev(8'hb0, 1'b1);
    u_eep_i2c_master.stop();
    dev(8'ha2, 1'b1);
    u_eep_i2c_master.stop();
    finish_test();
  end

  // Run needs well under 0.5 ms of bus traffic
  initial begin
    #1000000;
    bad_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule : i2c_eeprom_access_protocol_tb
`default_nettype wire
